/* rtl/optical_module_control_status.sv */
`timescale 1ns/100ps
`include "optmod_map.svh"
module optical_module_control_status
  import optmod_pkg::*;
#(
  parameter int INIT_CYCLES = `INIT_CYC
)
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       txOffIn,
  input  wire logic       laserFaultSense,
  input  wire logic       signalLostSense,
  input  wire monitor_t   monitorRaw,
  input  wire monitor_t   monitorTrim,
  input  wire logic       externalCal,
  input  wire logic       idWrEn,
  input  wire logic [6:0] idWrAddr,
  input  wire logic [7:0] idWrData,
  input  wire logic       sclIn,
  input  wire logic       sdaIn,
  output logic            sdaOut,
  output logic            sdaOe,
  output logic            presentOut,
  output logic            presentOe,
  output logic            laserOn,
  output logic            faultFlag,
  output logic            signalLostFlag,
  output logic            initDone
);

  localparam int RESET_CYCLES = `RESET_CYC;

  logic [2:0]   txOffSync_q;
  logic [2:0]   faultSync_q;
  logic [2:0]   lostSync_q;
  logic         txOff_q;
  logic         fault_q;
  logic         txOffNew;
  logic         faultNew;
  logic         lostNew;
  laser_state_t state_q;
  logic [22:0]  initCnt_q;
  logic [7:0]   holdCnt_q;
  logic         holdMet_q;
  monitor_t     monitor_q;
  logic [7:0]   idMem [0:127];
  logic [7:0]   idByte_q;
  logic         diagPage;
  logic [7:0]   rdAddr;
  logic [7:0]   rdData;
  logic [7:0]   diagByte;

  // Calibrated value when internal, raw when external
  function automatic logic [15:0] calib(input logic [15:0] raw,
                                        input logic [15:0] trim,
                                        input logic        ext);
    calib = ext ? raw : raw + trim;
  endfunction

  // Three-stage synchronisers for pin-level inputs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      txOffSync_q <= 3'h7;
      faultSync_q <= 3'h0;
      lostSync_q  <= 3'h7;
    end else begin
      txOffSync_q <= {txOffSync_q[1:0], txOffIn};
      faultSync_q <= {faultSync_q[1:0], laserFaultSense};
      lostSync_q  <= {lostSync_q[1:0], signalLostSense};
    end
  end

  // Accepted level once the last two stages agree
  assign txOffNew = (txOffSync_q[1] == txOffSync_q[2]) ?
                    txOffSync_q[2] : txOff_q;
  assign faultNew = (faultSync_q[1] == faultSync_q[2]) ?
                    faultSync_q[2] : fault_q;
  assign lostNew  = (lostSync_q[1] == lostSync_q[2]) ?
                    lostSync_q[2] : signalLostFlag;

  // Filtered levels; off input starts high as if open
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      txOff_q <= 1'b1;
      fault_q <= 1'b0;
    end else begin
      txOff_q <= txOffNew;
      fault_q <= faultNew;
    end
  end

  // Signal-lost flag follows the receiver a few cycles late
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      signalLostFlag <= 1'b1;
    end else begin
      signalLostFlag <= lostNew;
    end
  end

  // Laser control loop
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_INIT;
    end else begin
      unique case (state_q)
        ST_INIT: begin
          if (initCnt_q == 23'(INIT_CYCLES - 1)) begin
            state_q <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (fault_q) begin
            state_q <= ST_FAULT;
          end
        end
        ST_FAULT: begin
          if (holdMet_q && !txOff_q) begin
            state_q <= ST_INIT;
          end
        end
      endcase
    end
  end

  // Initialization timer, restarted on every entry
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      initCnt_q <= 23'h0;
    end else if (state_q != ST_INIT) begin
      initCnt_q <= 23'h0;
    end else if (initCnt_q != 23'(INIT_CYCLES - 1)) begin
      initCnt_q <= initCnt_q + 23'h1;
    end
  end

  // Off-input hold time while faulted
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      holdCnt_q <= 8'h0;
      holdMet_q <= 1'b0;
    end else if (state_q != ST_FAULT) begin
      holdCnt_q <= 8'h0;
      holdMet_q <= 1'b0;
    end else if (txOff_q) begin
      if (holdCnt_q == 8'(RESET_CYCLES - 1)) begin
        holdMet_q <= 1'b1;
      end else begin
        holdCnt_q <= holdCnt_q + 8'h1;
      end
    end else begin
      holdCnt_q <= 8'h0;
    end
  end

  // Laser drive and fault flag
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      laserOn   <= 1'b0;
      faultFlag <= 1'b0;
      initDone  <= 1'b0;
    end else begin
      laserOn   <= (state_q == ST_RUN) && !txOffNew && !fault_q;
      faultFlag <= (state_q == ST_FAULT) ||
                   ((state_q == ST_RUN) && fault_q);
      initDone  <= (state_q != ST_INIT);
    end
  end

  // Presence line pulled to ground permanently
  assign presentOut = 1'b0;
  assign presentOe  = 1'b1;

  // Monitor readings, refreshed each cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      monitor_q <= '0;
    end else begin
      monitor_q.temp  <= calib(monitorRaw.temp, monitorTrim.temp,
                               externalCal);
      monitor_q.vcc   <= calib(monitorRaw.vcc, monitorTrim.vcc,
                               externalCal);
      monitor_q.bias  <= calib(monitorRaw.bias, monitorTrim.bias,
                               externalCal);
      monitor_q.txPwr <= calib(monitorRaw.txPwr, monitorTrim.txPwr,
                               externalCal);
      monitor_q.rxPwr <= calib(monitorRaw.rxPwr, monitorTrim.rxPwr,
                               externalCal);
    end
  end

  // Identity store, loaded from the factory port
  always_ff @(posedge clk) begin
    if (idWrEn) begin
      idMem[idWrAddr] <= idWrData;
    end
  end

  // Registered identity read; upper half reads zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      idByte_q <= 8'h00;
    end else begin
      idByte_q <= rdAddr[7] ? 8'h00 : idMem[rdAddr[6:0]];
    end
  end

  // Diagnostic page decode
  always_comb begin
    unique case (rdAddr)
      `DG_TEMP_HI: diagByte = monitor_q.temp[15:8];
      `DG_TEMP_LO: diagByte = monitor_q.temp[7:0];
      `DG_VCC_HI:  diagByte = monitor_q.vcc[15:8];
      `DG_VCC_LO:  diagByte = monitor_q.vcc[7:0];
      `DG_BIAS_HI: diagByte = monitor_q.bias[15:8];
      `DG_BIAS_LO: diagByte = monitor_q.bias[7:0];
      `DG_TXP_HI:  diagByte = monitor_q.txPwr[15:8];
      `DG_TXP_LO:  diagByte = monitor_q.txPwr[7:0];
      `DG_RXP_HI:  diagByte = monitor_q.rxPwr[15:8];
      `DG_RXP_LO:  diagByte = monitor_q.rxPwr[7:0];
      `DG_STATUS:  diagByte = {5'h0, txOff_q, faultFlag, signalLostFlag};
      `DG_CALTYPE: diagByte = {7'h0, externalCal};
      default:     diagByte = `DG_PAD;
    endcase
  end

  // Byte handed to the serial target
  assign rdData = diagPage ? diagByte : idByte_q;

  // Serial target on clock and data lines
  twowire_target u_twowire (
    .clk      (clk),
    .rst      (rst),
    .sclIn    (sclIn),
    .sdaIn    (sdaIn),
    .sdaOut   (sdaOut),
    .sdaOe    (sdaOe),
    .diagPage (diagPage),
    .rdAddr   (rdAddr),
    .rdData   (rdData)
  );

endmodule

/* rtl/optmod_map.svh */
// How it works
// - Laser off within 10 us of off input
// - Laser back on within 1 ms of release
// - Initialization, fault flag cleared, within 300 ms
// - Fault flag inside 100 us; 10 us reset
// - Fault flag high on fault, held until off-input reset
// - Signal-lost flag follows input inside 100 us
// - Off input low enables; high or open disables
// - Presence line held at ground
// - Identity and diagnostics readable over serial bus
// - Five monitors, internal or external calibration
// - One line clock, one line data
`ifndef OPTMOD_MAP_SVH
`define OPTMOD_MAP_SVH

// Clock rate and printed times
`define CLK_MHZ        20
`define T_OFF_US       10
`define T_ON_US        1000
`define T_INIT_MS      300
`define T_FAULT_US     100
`define T_RESET_US     10
`define T_LOSS_US      100
`define SCL_MAX_KHZ    400

// Derived cycle counts
`define OFF_CYC        (`T_OFF_US * `CLK_MHZ)
`define ON_CYC         (`T_ON_US * `CLK_MHZ)
`define INIT_CYC       (`T_INIT_MS * 1000 * `CLK_MHZ)
`define RESET_CYC      (`T_RESET_US * `CLK_MHZ)
`define LOSS_CYC       (`T_LOSS_US * `CLK_MHZ)

// Serial bus target addresses (7 bit)
`define ID_DEV_ADDR    7'h50
`define DIAG_DEV_ADDR  7'h51

// Diagnostic page layout
`define DG_TEMP_HI     8'h00
`define DG_TEMP_LO     8'h01
`define DG_VCC_HI      8'h02
`define DG_VCC_LO      8'h03
`define DG_BIAS_HI     8'h04
`define DG_BIAS_LO     8'h05
`define DG_TXP_HI      8'h06
`define DG_TXP_LO      8'h07
`define DG_RXP_HI      8'h08
`define DG_RXP_LO      8'h09
`define DG_STATUS      8'h0a
`define DG_CALTYPE     8'h0b
`define DG_PAD         8'h00

`endif

/* rtl/optmod_pkg.sv */
package optmod_pkg;

  // Five monitored quantities
  typedef struct packed {
    logic [15:0] temp;
    logic [15:0] vcc;
    logic [15:0] bias;
    logic [15:0] txPwr;
    logic [15:0] rxPwr;
  } monitor_t;

  // Control loop states
  typedef enum logic [1:0] {
    ST_INIT,
    ST_RUN,
    ST_FAULT
  } laser_state_t;

  // Serial target states
  typedef enum logic [1:0] {
    TW_IDLE,
    TW_ADDR,
    TW_WRITE,
    TW_READ
  } tw_state_t;

endpackage

/* rtl/twowire_target.sv */
`timescale 1ns/100ps
`include "optmod_map.svh"
module twowire_target
  import optmod_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       sclIn,
  input  wire logic       sdaIn,
  output logic            sdaOut,
  output logic            sdaOe,
  output logic            diagPage,
  output logic [7:0]      rdAddr,
  input  wire logic [7:0] rdData
);

  logic [2:0] sclSync_q;
  logic [2:0] sdaSync_q;
  logic       sclLvl_q;
  logic       sdaLvl_q;
  logic       sclNew;
  logic       sdaNew;
  logic       sclRise;
  logic       sclFall;
  logic       startEv;
  logic       stopEv;
  tw_state_t  state_q;
  logic [3:0] cnt_q;
  logic [7:0] shift_q;
  logic [7:0] txByte_q;
  logic       firstWr_q;
  logic       addrHit;

  // Three-stage synchronisers on both lines
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sclSync_q <= 3'h7;
      sdaSync_q <= 3'h7;
      sclLvl_q  <= 1'b1;
      sdaLvl_q  <= 1'b1;
    end else begin
      sclSync_q <= {sclSync_q[1:0], sclIn};
      sdaSync_q <= {sdaSync_q[1:0], sdaIn};
      sclLvl_q  <= sclNew;
      sdaLvl_q  <= sdaNew;
    end
  end

  // Level accepted once stages two and three agree
  assign sclNew  = (sclSync_q[1] == sclSync_q[2]) ? sclSync_q[2] : sclLvl_q;
  assign sdaNew  = (sdaSync_q[1] == sdaSync_q[2]) ? sdaSync_q[2] : sdaLvl_q;
  assign sclRise = sclNew & ~sclLvl_q;
  assign sclFall = ~sclNew & sclLvl_q;
  assign startEv = sclLvl_q & sclNew & sdaLvl_q & ~sdaNew;
  assign stopEv  = sclLvl_q & sclNew & ~sdaLvl_q & sdaNew;
  assign addrHit = (shift_q[7:1] == `ID_DEV_ADDR) ||
                   (shift_q[7:1] == `DIAG_DEV_ADDR);

  // Byte framing, pointer and page select
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q   <= TW_IDLE;
      cnt_q     <= 4'h0;
      shift_q   <= 8'h00;
      firstWr_q <= 1'b0;
      diagPage  <= 1'b0;
      rdAddr    <= 8'h00;
    end else if (startEv) begin
      state_q <= TW_ADDR;
      cnt_q   <= 4'h0;
    end else if (stopEv) begin
      state_q <= TW_IDLE;
    end else if (sclRise && state_q != TW_IDLE) begin
      shift_q <= {shift_q[6:0], sdaNew};
      cnt_q   <= (cnt_q == 4'h8) ? 4'h0 : cnt_q + 4'h1;
      if (cnt_q == 4'h8) begin
        unique case (state_q)
          TW_ADDR: begin
            if (!addrHit) begin
              state_q <= TW_IDLE;
            end else begin
              diagPage  <= shift_q[1];
              firstWr_q <= ~shift_q[0];
              state_q   <= shift_q[0] ? TW_READ : TW_WRITE;
            end
          end
          TW_WRITE: begin // Pointer set; later data bytes only advance it
            if (firstWr_q) begin
              rdAddr <= shift_q;
            end else begin
              rdAddr <= rdAddr + 8'h01;
            end
            firstWr_q <= 1'b0;
          end
          TW_READ: begin // Master nack ends the read
            if (sdaNew) begin
              state_q <= TW_IDLE;
            end
            rdAddr <= rdAddr + 8'h01;
          end
          TW_IDLE: begin
            state_q <= TW_IDLE;
          end
        endcase
      end
    end
  end

  // Open-drain data drive, changed on clock falls
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sdaOe    <= 1'b0;
      txByte_q <= 8'h00;
    end else if (startEv || stopEv) begin
      sdaOe <= 1'b0;
    end else if (sclFall) begin
      unique case (state_q)
        TW_ADDR:  sdaOe <= (cnt_q == 4'h8) && addrHit;
        TW_WRITE: sdaOe <= (cnt_q == 4'h8);
        TW_READ: begin
          if (cnt_q == 4'h0) begin
            txByte_q <= rdData;
            sdaOe    <= ~rdData[7];
          end else if (cnt_q < 4'h8) begin
            txByte_q <= {txByte_q[6:0], 1'b0};
            sdaOe    <= ~txByte_q[6];
          end else begin
            sdaOe <= 1'b0;
          end
        end
        TW_IDLE:  sdaOe <= 1'b0;
      endcase
    end
  end

  // Line only ever pulled low
  assign sdaOut = 1'b0;

endmodule

/* tb/host_model.sv */
`timescale 1ns/100ps
module host_model (
  input  wire logic clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sdaLow
);
  // 52 clocks a bit, about 385 kHz
  localparam int QTR = 13;

  // Bus idles released, clock standing high
  initial begin
    scl = 1'b1;
    sdaLow = 1'b0;
  end
  task automatic q();
    repeat (QTR) @(posedge clk);
  endtask
  // One bit out, data changed while clock low
  task automatic put(input logic b);
    sdaLow <= !b;
    q();
    scl <= 1'b1;
    q();
    q();
    scl <= 1'b0;
    q();
  endtask
  task automatic get(output logic b);
    sdaLow <= 1'b0;
    q();
    scl <= 1'b1;
    q();
    b = sda;
    q();
    scl <= 1'b0;
    q();
  endtask
  // Start or repeated start
  task automatic start();
    if (!scl) begin
      sdaLow <= 1'b0;
      q();
      scl <= 1'b1;
      q();
    end
    sdaLow <= 1'b1;
    q();
    scl <= 1'b0;
    q();
  endtask
  task automatic send(input logic [7:0] v, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) put(v[i]);
    get(b);
    ack = !b;
  endtask
  // Pointer write, repeated start, two bytes read
  task automatic read16(input logic [6:0] dev, input logic [7:0] ptr,
                        output logic [15:0] val, output logic ack);
    logic a0, a1, a2, b;
    start();
    send({dev, 1'b0}, a0);
    send(ptr, a1);
    start();
    send({dev, 1'b1}, a2);
    for (int j = 0; j < 2; j++) begin
      for (int i = 0; i < 8; i++) begin
        get(b);
        val = {val[14:0], b};
      end
      put(j == 1);
    end
    sdaLow <= 1'b1;
    q();
    scl <= 1'b1;
    q();
    sdaLow <= 1'b0;
    q();
    ack = a0 & a1 & a2;
  endtask
endmodule

/* tb/optmod_sva.sv */
`timescale 1ns/100ps
module optmod_sva
  import optmod_pkg::*;
#(
  parameter int INIT_CYCLES = 50
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic txOffIn,
  input wire logic laserFaultSense,
  input wire logic signalLostSense,
  input wire logic sdaOut,
  input wire logic presentOut,
  input wire logic presentOe,
  input wire logic laserOn,
  input wire logic faultFlag,
  input wire logic signalLostFlag,
  input wire logic initDone
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  logic [31:0] waitCnt_q;

  // Cycles spent initializing
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      waitCnt_q <= 32'h0;
    end else if (initDone || faultFlag) begin
      waitCnt_q <= 32'h0;
    end else begin
      waitCnt_q <= waitCnt_q + 32'h1;
    end
  end

  AST_OFF_TIME: assert property ($rose(txOffIn) |-> ##[1:200] !laserOn)
    else $error("Laser still on after off input");
  AST_ON_TIME: assert property (
    $fell(txOffIn) && initDone && !faultFlag && !laserFaultSense
    |-> ##[1:1000] laserOn) else $error("Laser not restored");
  AST_INIT_TIME: assert property (waitCnt_q <= INIT_CYCLES + 16)
    else $error("Initialization too long");
  AST_INIT_DARK: assert property (!initDone |-> !laserOn)
    else $error("Laser on during init");
  AST_FAULT_TIME: assert property (
    $rose(laserFaultSense) && laserOn |-> ##[1:1000] faultFlag)
    else $error("Fault flag late");
  AST_FAULT_DARK: assert property (faultFlag |-> !laserOn)
    else $error("Laser on while faulted");
  AST_LOSS_FOLLOW: assert property (
    $stable(signalLostSense) [*8] |-> signalLostFlag == signalLostSense)
    else $error("Signal lost flag does not follow");
  AST_OFF_LEVEL: assert property (txOffIn [*6] |-> !laserOn)
    else $error("Laser on with off input high");
  AST_PRESENT: assert property (presentOe && !presentOut)
    else $error("Presence line not grounded");
  AST_SDA_DRAIN: assert property (!sdaOut)
    else $error("Data line driven high");
endmodule

bind optical_module_control_status optmod_sva #(
  .INIT_CYCLES(INIT_CYCLES)
) u_sva (
  .clk(clk), .rst(rst), .txOffIn(txOffIn),
  .laserFaultSense(laserFaultSense), .signalLostSense(signalLostSense),
  .sdaOut(sdaOut), .presentOut(presentOut), .presentOe(presentOe),
  .laserOn(laserOn), .faultFlag(faultFlag),
  .signalLostFlag(signalLostFlag), .initDone(initDone)
);

/* tb/tb.sv */
`timescale 1ns/100ps
`include "optmod_map.svh"
module tb;
  import optmod_pkg::*;
  localparam int INIT = 50;
  logic        clk, rst, txOffIn, laserFaultSense, signalLostSense;
  logic        externalCal, idWrEn, sdaOut, sdaOe, presentOut, presentOe;
  logic        laserOn, faultFlag, signalLostFlag, initDone, scl, sdaLow;
  logic        sda, a;
  logic [6:0]  idWrAddr;
  logic [7:0]  idWrData;
  logic [15:0] v;
  monitor_t    monitorRaw, monitorTrim;
  int          badCount, nChecks, cyc;

  // Open-drain data line with host pull-up
  assign sda = sdaLow ? 1'b0 : (sdaOe ? sdaOut : 1'b1);

  optical_module_control_status #(.INIT_CYCLES(INIT)) u_dut (
    .clk, .rst, .txOffIn, .laserFaultSense, .signalLostSense,
    .monitorRaw, .monitorTrim, .externalCal, .idWrEn, .idWrAddr,
    .idWrData, .sclIn(scl), .sdaIn(sda), .sdaOut, .sdaOe, .presentOut,
    .presentOe, .laserOn, .faultFlag, .signalLostFlag, .initDone
  );
  host_model u_host (.clk, .sda, .scl, .sdaLow);

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      badCount++;
      reportAndStop();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    nChecks++;
    if (got !== exp) begin
      badCount++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic reportAndStop();
    $display("checks=%0d mismatches=%0d", nChecks, badCount);
    if (badCount == 0 && nChecks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Bounded wait on one flag, sampled after the edge settles
  task automatic waitFor(input int which, input logic want, input int lim);
    logic [3:0] s;
    for (int k = 0; k < lim; k++) begin
      @(posedge clk);
      #1;
      s = {initDone, signalLostFlag, faultFlag, laserOn};
      if (s[which] === want) break;
    end
  endtask

  task automatic tReset();
    chk({10'h0, laserOn, faultFlag, signalLostFlag, initDone, presentOe,
         presentOut}, 16'h000a);
    @(posedge clk) rst <= 1'b0;
    waitFor(3, 1'b1, INIT + 16);
    chk(initDone, 1'b1);
    chk(faultFlag, 1'b0);
    chk(laserOn, 1'b0);
  endtask
  task automatic tTx();
    @(posedge clk) txOffIn <= 1'b0;
    waitFor(0, 1'b1, 200);
    chk(laserOn, 1'b1);
    @(posedge clk) txOffIn <= 1'b1;
    waitFor(0, 1'b0, 200);
    chk(laserOn, 1'b0);
  endtask
  task automatic tLoss();
    for (int k = 0; k < 4; k++) begin
      @(posedge clk) signalLostSense <= !k[0];
      waitFor(2, !k[0], 2000);
      chk(signalLostFlag, !k[0]);
    end
  endtask
  task automatic tFault();
    @(posedge clk) txOffIn <= 1'b0;
    waitFor(0, 1'b1, 200);
    @(posedge clk) laserFaultSense <= 1'b1;
    waitFor(1, 1'b1, 2000);
    chk(faultFlag, 1'b1);
    chk(laserOn, 1'b0);
    // Too short an off pulse leaves the fault latched
    @(posedge clk) txOffIn <= 1'b1;
    laserFaultSense <= 1'b0;
    repeat (100) @(posedge clk);
    txOffIn <= 1'b0;
    waitFor(1, 1'b0, 300);
    chk(faultFlag, 1'b1);
    @(posedge clk) txOffIn <= 1'b1;
    repeat (250) @(posedge clk);
    txOffIn <= 1'b0;
    waitFor(1, 1'b0, 20);
    chk(faultFlag, 1'b0);
    waitFor(0, 1'b1, INIT + 40);
    chk(laserOn, 1'b1);
  endtask
  task automatic tSerial();
    @(posedge clk) externalCal <= 1'b0;
    u_host.read16(`DIAG_DEV_ADDR, `DG_TEMP_HI, v, a);
    chk(a, 1'b1);
    chk(v, monitorRaw.temp + monitorTrim.temp);
    @(posedge clk) externalCal <= 1'b1;
    u_host.read16(`DIAG_DEV_ADDR, `DG_RXP_HI, v, a);
    chk(v, monitorRaw.rxPwr);
    // Status byte then calibration type: all clear, external
    u_host.read16(`DIAG_DEV_ADDR, `DG_STATUS, v, a);
    chk(a, 1'b1);
    chk(v, 16'h0001);
    @(posedge clk) idWrEn <= 1'b1;
    idWrAddr <= 7'h05;
    idWrData <= 8'h5a;
    @(posedge clk) idWrAddr <= 7'h06;
    idWrData <= 8'ha5;
    @(posedge clk) idWrEn <= 1'b0;
    u_host.read16(`ID_DEV_ADDR, 8'h05, v, a);
    chk(v, 16'h5aa5);
    u_host.read16(7'h30, 8'h00, v, a);
    chk(a, 1'b0);
  endtask

  initial begin
    rst = 1'b1;
    txOffIn = 1'b1;
    laserFaultSense = 1'b0;
    signalLostSense = 1'b0;
    externalCal = 1'b0;
    idWrEn = 1'b0;
    idWrAddr = 7'h00;
    idWrData = 8'h00;
    monitorRaw = {16'h1234, 16'h0ce4, 16'h0200, 16'h1000, 16'h0800};
    monitorTrim = {16'hfff1, 16'h0010, 16'h0003, 16'h0020, 16'h0041};
    badCount = 0;
    nChecks = 0;
    cyc = 0;
    repeat (20) @(posedge clk);
    tReset();
    tTx();
    tLoss();
    tFault();
    tSerial();
    reportAndStop();
  end
endmodule
